// ==== fsp_map.vh ====
/*
  Constants for the volatile status-one latch: opcodes, bit positions,
  the any-register address of the status register and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// Opcodes taken from the serial link
`define FSP_OP_STATUS_ONE_READ 8'h05
`define FSP_OP_STATUS_TWO_READ 8'h07
`define FSP_OP_ENABLE_VOLATILE 8'h50
`define FSP_OP_ENABLE_WRITES 8'h06
`define FSP_OP_DISABLE_WRITES 8'h04
`define FSP_OP_REGISTER_WRITE 8'h01
`define FSP_OP_STATUS_CLEAR 8'h30
`define FSP_OP_ANY_REG_READ 8'h65
`define FSP_OP_ANY_REG_WRITE 8'h71
`define FSP_OP_CONFIG_ONE_READ 8'h35
`define FSP_OP_CONFIG_TWO_READ 8'h15
`define FSP_OP_CONFIG_THREE_READ 8'h33
`define FSP_OP_SUSPEND 8'h75
`define FSP_OP_RESET_ARM 8'h66
`define FSP_OP_RESET_GO 8'h99
`define FSP_OP_PROGRAM 8'h02
`define FSP_OP_ERASE 8'h20

// Status one bit positions
`define FSP_BIT_LOCK_SELECT 7
`define FSP_BIT_FROM_BOTTOM 6
`define FSP_BIT_RANGE_HI 5
`define FSP_BIT_RANGE_LO 2
`define FSP_BIT_ENABLE_LATCH 1
`define FSP_BIT_BUSY 0

// Status two error bit positions
`define FSP_BIT_PROG_ERROR 6
`define FSP_BIT_ERASE_ERROR 5

// Any-register address of status one
`define FSP_ADDR_STATUS_ONE 24'h800000

// Frame lengths in bytes
`define FSP_LEN_REG_WRITE 3'h2
`define FSP_LEN_ANY_WRITE 3'h5
`define FSP_LEN_ARRAY_OP 3'h4
`define FSP_LEN_ANY_READ 3'h4

// Reset values before the non-volatile copy loads
`define FSP_RESET_STATUS 8'h00
`define FSP_RESET_BYTE 8'h00

`endif

// ==== fsp_sync.v ====
/*
  Two-flop synchroniser for a group of pins from outside the clock domain.
  Assumes the pins are quasi-static relative to clk_in.
*/
`timescale 1ns/10ps

module fsp_sync #(
  parameter WIDTH = 4
) (
  // Clock, reset, enable
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // Pins and synchronised levels
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] stage_one; // First stage, read only by stage two
  reg [WIDTH-1:0] stage_two; // Stable level

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Two flops per bit
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          stage_one[i] <= 1'b0;
          stage_two[i] <= 1'b0;
        end else if (ce_in) begin
          stage_one[i] <= pin_in[i];
          stage_two[i] <= stage_one[i];
        end
      end
    end
  endgenerate

  assign level_out = stage_two;

endmodule // fsp_sync

// ==== fsp_status_latch.v ====
/*
  Volatile status-one register with its serial command front end, the
  write-enable latch, the busy flag, error flags and the register lock.
  Assumes an array engine on clk_in that answers a start with a done
  pulse, and a non-volatile copy presented as a level.
*/
`timescale 1ns/10ps
`include "fsp_map.vh"

module fsp_status_latch (
  // Clock, reset, enable
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // Serial link pins
  input wire sck_in,
  input wire cs_n_in,
  input wire si_in,
  input wire wp_n_in,
  output reg so_out,
  output reg so_oe_out,
  // Mode levels from the configuration registers
  input wire four_line_command_mode_in,
  input wire four_bit_data_mode_in,
  // Non-volatile copy of status one
  input wire [7:0] status_one_nonvolatile_in,
  input wire nv_update_in,
  // Array engine handshake
  output reg op_start_out,
  output reg op_erase_out,
  output reg op_suspend_out,
  input wire op_done_in,
  input wire op_fail_in,
  // Register contents
  output reg [7:0] status_one_volatile_out,
  output reg program_error_out,
  output reg erase_error_out,
  output reg register_lock_out
);

  // Synchronised pins
  wire [3:0] pins_sync; // sck, cs_n, si, wp_n
  reg sck_prev; // Previous clock level
  reg cs_n_prev; // Previous select level
  wire sck_rise; // Link clock rising edge
  wire sck_fall; // Link clock falling edge
  wire frame_end; // Select released
  wire selected; // Select asserted

  // Link engine state
  reg [2:0] bit_count; // Bit within byte
  reg [2:0] byte_count; // Bytes taken, saturating
  reg [7:0] shift_reg; // Incoming bits
  reg [7:0] opcode; // First byte of frame
  reg [23:0] address; // Any-register address
  reg [7:0] data_byte; // Last byte taken, the data byte of a write
  reg cmd_ok; // Opcode passed busy gate
  reg tx_load; // Next falling edge loads a byte
  reg [7:0] tx_reg; // Outgoing bits
  reg reset_armed; // Arm byte seen
  reg load_pending; // Copy defaults after reset release
  reg array_running; // Array operation in flight
  reg [1:0] sync_warm; // Synchroniser filled since reset
  wire fail_event; // Failing finish in this cycle

  // Status register fields
  wire lock_select;
  wire enable_latch;
  wire busy;
  wire [7:0] shift_next;
  wire byte_done;
  wire wp_level;
  wire locked;
  wire in_error;
  reg gate_ok;
  reg [7:0] read_byte;
  reg [7:0] next_status;

  assign lock_select = status_one_volatile_out[`FSP_BIT_LOCK_SELECT];
  assign enable_latch = status_one_volatile_out[`FSP_BIT_ENABLE_LATCH];
  assign busy = status_one_volatile_out[`FSP_BIT_BUSY];
  assign in_error = program_error_out | erase_error_out;
  assign fail_event = op_done_in & array_running & op_fail_in;

  // Pin synchroniser
  fsp_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in({sck_in, cs_n_in, si_in, wp_n_in}),
    .level_out(pins_sync)
  );

  // Edges of the sampled link clock and select
  // Synchroniser resets low, so select counts only once it holds pin levels
  assign selected = ~pins_sync[2] & sync_warm[1];
  assign sck_rise = selected & pins_sync[3] & ~sck_prev;
  assign sck_fall = selected & ~pins_sync[3] & sck_prev;
  assign frame_end = ~selected & ~cs_n_prev;
  assign shift_next = {shift_reg[6:0], pins_sync[1]};
  assign byte_done = sck_rise & (bit_count == 3'h7);

  // Quad modes use the pin as data, so its level counts as high
  // Unfilled synchroniser must not fake a low protect pin
  assign wp_level = pins_sync[0] | ~sync_warm[1] | four_line_command_mode_in | four_bit_data_mode_in;
  // Lock only with select bit set and pin low
  assign locked = lock_select & ~wp_level;

  // Busy gate on the incoming opcode
  always @* begin
    case (shift_next)
      `FSP_OP_STATUS_ONE_READ, `FSP_OP_STATUS_TWO_READ, `FSP_OP_ANY_REG_READ,
      `FSP_OP_SUSPEND, `FSP_OP_STATUS_CLEAR, `FSP_OP_CONFIG_ONE_READ,
      `FSP_OP_CONFIG_TWO_READ, `FSP_OP_CONFIG_THREE_READ,
      `FSP_OP_RESET_ARM, `FSP_OP_RESET_GO: begin
        gate_ok = 1'b1;
      end
      default: begin
        gate_ok = ~busy;
      end
    endcase
  end

  // Byte returned on the next output byte
  always @* begin
    read_byte = `FSP_RESET_BYTE;
    case (opcode)
      `FSP_OP_STATUS_ONE_READ: begin
        read_byte = status_one_volatile_out;
      end
      `FSP_OP_STATUS_TWO_READ: begin
        read_byte[`FSP_BIT_PROG_ERROR] = program_error_out;
        read_byte[`FSP_BIT_ERASE_ERROR] = erase_error_out;
      end
      `FSP_OP_ANY_REG_READ: begin
        if (address == `FSP_ADDR_STATUS_ONE) begin
          read_byte = status_one_volatile_out;
        end
      end
      default: begin
        read_byte = `FSP_RESET_BYTE;
      end
    endcase
  end

  // Host write data; latch and busy positions keep internal values
  always @* begin
    next_status = status_one_volatile_out;
    next_status[`FSP_BIT_LOCK_SELECT:`FSP_BIT_RANGE_LO] = data_byte[7:2];
  end

  // Link receive and transmit engine
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_prev <= 1'b0;
      cs_n_prev <= 1'b1;
      sync_warm <= 2'b00;
      bit_count <= 3'h0;
      byte_count <= 3'h0;
      shift_reg <= `FSP_RESET_BYTE;
      opcode <= `FSP_RESET_BYTE;
      address <= 24'h000000;
      data_byte <= `FSP_RESET_BYTE;
      cmd_ok <= 1'b0;
      tx_load <= 1'b0;
      tx_reg <= `FSP_RESET_BYTE;
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
    end else if (ce_in) begin
      sck_prev <= pins_sync[3];
      cs_n_prev <= ~selected;
      sync_warm <= {sync_warm[0], 1'b1};
      if (!selected) begin
        // Idle between frames
        bit_count <= 3'h0;
        byte_count <= 3'h0;
        tx_load <= 1'b0;
        so_oe_out <= 1'b0;
      end else begin
        if (sck_rise) begin
          // Sample input on rising edge
          shift_reg <= shift_next;
          bit_count <= bit_count + 3'h1;
        end
        if (byte_done) begin
          // Byte complete
          if (byte_count != 3'h7) begin
            byte_count <= byte_count + 3'h1;
          end
          if (byte_count == 3'h0) begin
            opcode <= shift_next;
            cmd_ok <= gate_ok;
          end else if (byte_count < 3'h4) begin
            address <= {address[15:0], shift_next};
          end
          data_byte <= shift_next;
          tx_load <= 1'b1;
        end
        if (sck_fall) begin
          // Drive output on falling edge
          if (tx_load) begin
            tx_load <= 1'b0;
            so_out <= read_byte[7];
            tx_reg <= {read_byte[6:0], 1'b0};
            so_oe_out <= cmd_ok & (opcode == `FSP_OP_STATUS_ONE_READ
              | opcode == `FSP_OP_STATUS_TWO_READ
              | opcode == `FSP_OP_CONFIG_ONE_READ
              | opcode == `FSP_OP_CONFIG_TWO_READ
              | opcode == `FSP_OP_CONFIG_THREE_READ
              | (opcode == `FSP_OP_ANY_REG_READ & byte_count >= `FSP_LEN_ANY_READ));
          end else begin
            so_out <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Register state: command effects at frame end, engine events
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_one_volatile_out <= `FSP_RESET_STATUS;
      program_error_out <= 1'b0;
      erase_error_out <= 1'b0;
      register_lock_out <= 1'b0;
      reset_armed <= 1'b0;
      load_pending <= 1'b1;
      array_running <= 1'b0;
      op_start_out <= 1'b0;
      op_erase_out <= 1'b0;
      op_suspend_out <= 1'b0;
    end else if (ce_in) begin
      op_start_out <= 1'b0;
      op_suspend_out <= 1'b0;
      register_lock_out <= locked;
      if (load_pending) begin
        // Copy defaults once after reset release
        load_pending <= 1'b0;
        status_one_volatile_out <= status_one_nonvolatile_in;
      end else begin
        if (nv_update_in) begin
          // Track the non-volatile lock-select and from-bottom bits
          status_one_volatile_out[`FSP_BIT_LOCK_SELECT] <=
            status_one_nonvolatile_in[`FSP_BIT_LOCK_SELECT];
          status_one_volatile_out[`FSP_BIT_FROM_BOTTOM] <=
            status_one_nonvolatile_in[`FSP_BIT_FROM_BOTTOM];
        end
        if (op_done_in && array_running) begin
          // Array operation finished
          array_running <= 1'b0;
          if (op_fail_in) begin
            // Failure: flag error, stay busy, keep latch
            program_error_out <= ~op_erase_out;
            erase_error_out <= op_erase_out;
          end else begin
            status_one_volatile_out[`FSP_BIT_BUSY] <= 1'b0;
            status_one_volatile_out[`FSP_BIT_ENABLE_LATCH] <= 1'b0;
          end
        end
        if (frame_end && byte_count != 3'h0) begin
          // Any other frame disarms the reset pair
          reset_armed <= 1'b0;
          if (cmd_ok) begin
            case (opcode)
              `FSP_OP_ENABLE_WRITES, `FSP_OP_ENABLE_VOLATILE: begin
                status_one_volatile_out[`FSP_BIT_ENABLE_LATCH] <= 1'b1;
              end
              `FSP_OP_DISABLE_WRITES: begin
                status_one_volatile_out[`FSP_BIT_ENABLE_LATCH] <= 1'b0;
              end
              `FSP_OP_STATUS_CLEAR: begin
                // Clears errors, latch and error-held busy
                status_one_volatile_out[`FSP_BIT_ENABLE_LATCH] <= 1'b0;
                if (!fail_event) begin
                  // A failure in this same cycle keeps its flags and busy
                  program_error_out <= 1'b0;
                  erase_error_out <= 1'b0;
                  if (in_error) begin
                    status_one_volatile_out[`FSP_BIT_BUSY] <= 1'b0;
                  end
                end
              end
              `FSP_OP_REGISTER_WRITE: begin
                // Complete frame, latch set, not locked
                if (byte_count == `FSP_LEN_REG_WRITE && enable_latch && !locked) begin
                  status_one_volatile_out <= next_status;
                end
              end
              `FSP_OP_ANY_REG_WRITE: begin
                // Lock applies only to the status register
                if (byte_count == `FSP_LEN_ANY_WRITE && enable_latch) begin
                  if (address == `FSP_ADDR_STATUS_ONE && !locked) begin
                    status_one_volatile_out <= next_status;
                  end
                end
              end
              `FSP_OP_PROGRAM, `FSP_OP_ERASE: begin
                // Start array operation if enabled
                if (byte_count == `FSP_LEN_ARRAY_OP && enable_latch) begin
                  status_one_volatile_out[`FSP_BIT_BUSY] <= 1'b1;
                  array_running <= 1'b1;
                  op_start_out <= 1'b1;
                  op_erase_out <= (opcode == `FSP_OP_ERASE);
                end
              end
              `FSP_OP_SUSPEND: begin
                // Only while array work runs without error
                if (array_running && !in_error) begin
                  op_suspend_out <= 1'b1;
                end
              end
              `FSP_OP_RESET_ARM: begin
                reset_armed <= 1'b1;
              end
              `FSP_OP_RESET_GO: begin
                // Software reset reloads defaults
                if (reset_armed) begin
                  load_pending <= 1'b1;
                  program_error_out <= 1'b0;
                  erase_error_out <= 1'b0;
                  array_running <= 1'b0;
                end
              end
              default: begin
                reset_armed <= 1'b0;
              end
            endcase
          end
        end
      end
    end
  end

endmodule // fsp_status_latch

// ==== fsp_host_model.sv ====
/*
  Host serial controller model: mode-0 frames, MSB first, clock low at rest.
  Assumes the caller starts each frame just after a clk_in edge.
*/
`timescale 1ns/10ps
module fsp_host_model (
  // Link outputs
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  // Read data from the device
  input wire logic so_in
);
  // Idle link levels
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // Frame of n bytes taken from the top of d; rd keeps the last byte seen
  task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    cs_n_out = 1'b0;
    #32;
    for (i = 0; i < n * 8; i++) begin
      si_out = d[39-i]; // Drive while clock is low
      #32;
      sck_out = 1'b1;
      rd = {rd[6:0], so_in}; // Sample on the rise
      #32;
      sck_out = 1'b0;
    end
    si_out = ~si_out; // Released line shows no stale value
    #32;
    cs_n_out = 1'b1;
    #200;
  endtask
endmodule // fsp_host_model

// ==== fsp_status_latch_chk.sv ====
/*
  Port checker for the status-one latch.
  Assumes it is bound to fsp_status_latch with ce_in held high.
*/
`timescale 1ns/10ps
module fsp_status_latch_chk (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // Link and modes
  input wire cs_n_in,
  input wire so_oe_out,
  input wire four_line_command_mode_in,
  input wire four_bit_data_mode_in,
  // Non-volatile copy
  input wire [7:0] status_one_nonvolatile_in,
  input wire nv_update_in,
  // Engine handshake
  input wire op_start_out,
  input wire op_suspend_out,
  input wire op_done_in,
  input wire op_fail_in,
  // Register contents
  input wire [7:0] status_one_volatile_out,
  input wire program_error_out,
  input wire erase_error_out,
  input wire register_lock_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire [7:0] st = status_one_volatile_out; // Short alias
  wire err = program_error_out | erase_error_out; // Any error flag
  wire quad = four_line_command_mode_in | four_bit_data_mode_in; // Pin used as data
  start_latch_a: assert property (op_start_out |-> st[0] && $past(st[1]))
    else $error("start without latch or busy");
  done_ok_a: assert property (ce_in && st[0] && op_done_in && !op_fail_in && !err && !op_start_out
    |=> st[1:0] == 2'b00) else $error("good finish left latch or busy");
  done_bad_a: assert property (st[0] && op_done_in && op_fail_in && !err
    |=> err && st[1:0] == $past(st[1:0])) else $error("failed op lost busy or latch");
  err_busy_a: assert property (err |-> st[0]) else $error("error without busy");
  nv_follow_a: assert property (nv_update_in |=> st[7:6] == $past(status_one_nonvolatile_in[7:6]))
    else $error("lock or reference did not follow copy");
  reset_load_a: assert property ($past(rst_in) |=> st == $past(status_one_nonvolatile_in))
    else $error("reset did not load copy");
  lock_sel_a: assert property (register_lock_out |-> $past(st[7])) else $error("lock without select");
  quad_free_a: assert property (quad [*3] |-> !register_lock_out) else $error("lock held in quad mode");
  so_quiet_a: assert property (cs_n_in [*8] |-> !so_oe_out) else $error("output driven while deselected");
  suspend_busy_a: assert property (op_suspend_out |-> st[0]) else $error("suspend while idle");
  start_c: cover property (op_start_out);
  error_c: cover property (erase_error_out);
  suspend_c: cover property (op_suspend_out);
  lock_c: cover property (register_lock_out);
endmodule // fsp_status_latch_chk
bind fsp_status_latch fsp_status_latch_chk fsp_status_latch_chk_i (.clk_in, .rst_in, .ce_in, .cs_n_in,
  .so_oe_out, .four_line_command_mode_in, .four_bit_data_mode_in, .status_one_nonvolatile_in, .nv_update_in,
  .op_start_out, .op_suspend_out, .op_done_in, .op_fail_in, .status_one_volatile_out, .program_error_out,
  .erase_error_out, .register_lock_out);

// ==== tb_fsp_status_latch.sv ====
/*
  Testbench for the status-one latch: host model frames, engine pulses by hand.
  Assumes the checker is bound and clk_in runs at 125 MHz.
*/
`timescale 1ns/10ps
`include "fsp_map.vh"
module tb_fsp_status_latch;
  logic clk_in = 1'b0, rst_in = 1'b1, wp_n = 1'b0, qc = 1'b0, qd = 1'b0, nv_upd = 1'b0;
  logic done = 1'b0, fail = 1'b0;
  logic [7:0] nv = 8'hc2, rd;
  wire sck, cs_n, si, so, oe, start, erase, susp, perr, eerr, lock;
  wire [7:0] st;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, n_start = 0, n_susp = 0, n_oe = 0;
  fsp_host_model fsp_host_model_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));
  fsp_status_latch fsp_status_latch_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .sck_in(sck),
    .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n), .so_out(so), .so_oe_out(oe), .four_line_command_mode_in(qc),
    .four_bit_data_mode_in(qd), .status_one_nonvolatile_in(nv), .nv_update_in(nv_upd), .op_start_out(start),
    .op_erase_out(erase), .op_suspend_out(susp), .op_done_in(done), .op_fail_in(fail),
    .status_one_volatile_out(st), .program_error_out(perr), .erase_error_out(eerr), .register_lock_out(lock));
  // Clock
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  // Pulse counters and hang limit
  always @(posedge clk_in) begin
    cycles++;
    if (start) n_start++;
    if (susp) n_susp++;
    if (oe) n_oe++;
    if (cycles == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("Compared %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic fr(input logic [39:0] d, input int n);
    @(posedge clk_in) #1;
    fsp_host_model_i.frame(d, n, rd);
  endtask
  task automatic cmd(input logic [7:0] op);
    fr({op, 32'h0}, 1);
  endtask
  task automatic wr(input logic [7:0] v);
    fr({`FSP_OP_REGISTER_WRITE, v, 24'h0}, 2);
  endtask
  task automatic chk_st(input logic [7:0] exp);
    fr({`FSP_OP_STATUS_ONE_READ, 32'h0}, 2);
    cmp("status read", exp, rd);
    cmp("status port", exp, st);
  endtask
  task automatic finish_op(input logic f);
    @(posedge clk_in) #1;
    fail = f;
    done = 1'b1;
    @(posedge clk_in) #1;
    done = 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic s_lock;
    chk_st(8'hc2);
    cmp("drive", 8'h01, 8'(n_oe != 0));
    cmp("lock", 8'h01, {7'h0, lock});
    wr(8'h3d);
    chk_st(8'hc2);
    wp_n = 1'b1;
    wr(8'h3d);
    chk_st(8'h3e);
  endtask
  task automatic s_modes;
    wp_n = 1'b0;
    cmd(`FSP_OP_ENABLE_WRITES);
    wr(8'hbc);
    chk_st(8'hbe);
    qc = 1'b1;
    cmd(`FSP_OP_ENABLE_WRITES);
    wr(8'h80);
    chk_st(8'h82);
    qc = 1'b0;
    qd = 1'b1;
    cmd(`FSP_OP_ENABLE_WRITES);
    wr(8'hc0);
    chk_st(8'hc2);
    qd = 1'b0;
    fr({`FSP_OP_ANY_REG_WRITE, `FSP_ADDR_STATUS_ONE, 8'h3c}, 5);
    fr({`FSP_OP_ANY_REG_READ, `FSP_ADDR_STATUS_ONE, 8'h00}, 5);
    cmp("any read", 8'hc2, rd);
    cmd(`FSP_OP_ENABLE_WRITES);
    chk_st(8'hc2);
    nv = 8'h40;
    @(posedge clk_in) #1 nv_upd = 1'b1;
    @(posedge clk_in) #1 nv_upd = 1'b0;
    chk_st(8'h42);
  endtask
  task automatic s_program;
    cmd(`FSP_OP_DISABLE_WRITES);
    chk_st(8'h40);
    wr(8'hfc);
    chk_st(8'h40);
    cmd(`FSP_OP_ENABLE_VOLATILE);
    chk_st(8'h42);
    fr({`FSP_OP_PROGRAM, 32'h0}, 4);
    chk_st(8'h43);
    cmp("starts", 8'h01, 8'(n_start));
    cmd(`FSP_OP_DISABLE_WRITES);
    chk_st(8'h43);
    cmd(`FSP_OP_SUSPEND);
    cmp("suspends", 8'h01, 8'(n_susp));
    finish_op(1'b0);
    chk_st(8'h40);
    cmd(`FSP_OP_SUSPEND);
    fr({`FSP_OP_PROGRAM, 32'h0}, 4);
    cmp("suspends", 8'h01, 8'(n_susp));
    cmp("starts", 8'h01, 8'(n_start));
  endtask
  task automatic s_fail;
    cmd(`FSP_OP_ENABLE_WRITES);
    fr({`FSP_OP_ERASE, 32'h0}, 4);
    cmp("erase", 8'h01, {7'h0, erase});
    finish_op(1'b1);
    chk_st(8'h43);
    cmp("errors", 8'h01, {6'h0, perr, eerr});
    fr({`FSP_OP_PROGRAM, 32'h0}, 4);
    cmp("starts", 8'h02, 8'(n_start));
    cmd(`FSP_OP_STATUS_CLEAR);
    chk_st(8'h40);
    cmp("errors", 8'h00, {6'h0, perr, eerr});
  endtask
  task automatic s_soft;
    cmd(`FSP_OP_ENABLE_VOLATILE);
    nv = 8'h04;
    cmd(`FSP_OP_RESET_ARM);
    cmd(`FSP_OP_RESET_GO);
    chk_st(8'h04);
    nv = 8'h82;
    @(posedge clk_in) #1 rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 1'b0;
    chk_st(8'h82);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    #1 rst_in = 1'b0;
    s_lock();
    s_modes();
    s_program();
    s_fail();
    s_soft();
    print_verdict();
  end
endmodule // tb_fsp_status_latch
